// ### sbc_motor_model.sv
// Behavioural spindle motor that ramps after a run command change.
`timescale 1ns/1ns
module sbc_motor_model (
	input wire logic core_clk, // Clock.
	input wire logic motor_on, // Spindle run command.
	input wire logic [7:0] spin_cycles, // Ramp length in cycles.
	output logic motor_at_speed, // Spindle at speed.
	output logic motor_stopped // Spindle at rest.
);
	logic [7:0] cnt_ff;
	logic on_ff;

	// ----------------------------------------------------------------
	// Ramp
	// ----------------------------------------------------------------
	// The motor starts at rest, as after power-up.
	initial begin
		motor_at_speed = 1'b0;
		motor_stopped = 1'b1;
		cnt_ff = 8'h00;
		on_ff = 1'b0;
	end

	// A changed command starts a ramp; both levels drop while it runs.
	always @(posedge core_clk) begin
		if (motor_on !== on_ff) begin
			on_ff <= motor_on;
			cnt_ff <= spin_cycles;
			motor_at_speed <= 1'b0;
			motor_stopped <= 1'b0;
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
		end else begin
			motor_at_speed <= on_ff;
			motor_stopped <= !on_ff;
		end
	end
endmodule

// ### sbc_pkg.sv
// Shared constants and types for the standby command handler.
package sbc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_SECT_CNT = 4'h2;
	localparam logic [3:0] ADDR_DRV_HEAD = 4'h6;
	localparam logic [3:0] ADDR_CMD_STAT = 4'h7;
	localparam logic [3:0] ADDR_ERR = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
	localparam logic [3:0] ADDR_PWR_STAT = 4'hA;
	localparam logic [3:0] ADDR_TMO_VAL = 4'hB;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_STBY_TMR = 8'hE2;
	localparam logic [7:0] CMD_STBY_TMR_ALT = 8'h96;
	localparam logic [7:0] CMD_STBY_NOW = 8'hE0;
	localparam logic [7:0] CMD_STBY_NOW_ALT = 8'h94;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int DRV_SEL_BIT = 4;
	localparam int ERR_ABRT_BIT = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_AUTO_BIT = 1;
	localparam int IRQ_READY_BIT = 2;
	localparam logic [7:0] RST_SECT_CNT = 8'h01;
	localparam logic [7:0] RST_DRV_HEAD = 8'hA0;
	localparam logic [7:0] RST_TMO_VAL = 8'h00;
	localparam logic [2:0] RST_IRQ_MASK = 3'h0;

	// ----------------------------------------------------------------
	// Timeout table
	// ----------------------------------------------------------------
	localparam logic [7:0] TMO_SHORT_MAX = 8'hF0;
	localparam logic [7:0] TMO_LONG_MAX = 8'hFB;
	localparam logic [7:0] TMO_V252 = 8'hFC;
	localparam logic [7:0] TMO_V253 = 8'hFD;
	localparam logic [7:0] TMO_V254 = 8'hFE;
	localparam logic [14:0] TMO_STEP_S = 15'd5;
	localparam logic [14:0] TMO_HALF_HOUR_S = 15'd1800;
	localparam logic [14:0] TMO_252_S = 15'd1260;
	localparam logic [14:0] TMO_253_S = 15'd28800;
	localparam logic [14:0] TMO_254_S = 15'd1270;
	localparam logic [14:0] TMO_255_S = 15'd1275;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int SECOND_S = 1;
	localparam int SEC_CYCLES = CLK_HZ * SECOND_S;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_STBY,
		PWR_SPIN_UP,
		PWR_IDLE,
		PWR_SPIN_DN
	} sbc_pwr_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} sbc_req_s;

endpackage

// ### sbc_top.sv
// Standby command handler with automatic power-down timer.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
module sbc_top #(
	parameter int TICK_CYCLES = sbc_pkg::SEC_CYCLES, // Cycles per second.
	parameter logic DRIVE_ID = 1'b0 // Drive select bit this unit answers.
) (
	input wire logic core_clk, // 10 MHz clock.
	input wire logic nrst, // Asynchronous reset, active low.
	input wire sbc_pkg::sbc_req_s req, // Register access request.
	input wire logic motor_at_speed, // Spindle at operating speed.
	input wire logic motor_stopped, // Spindle fully stopped.
	output logic [7:0] rdata_ff, // Read data, cycle after the read.
	output logic motor_on_ff, // Spindle run command.
	output logic media_go_ff, // Pulse: media command may proceed.
	output logic standby_ff, // Drive is in standby.
	output logic irq_ff // Level interrupt.
);
	import sbc_pkg::*;

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_n_ff;

	// Releases reset two clocks after nrst rises.
	// Only the second flop feeds the design; the first may go metastable.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [7:0] sect_cnt_ff;
	logic [7:0] drv_head_ff;
	logic [7:0] tmo_val_ff;
	logic [7:0] err_ff;
	logic err_flag_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_mask_ff;
	logic media_pend_ff;
	logic [14:0] secs_left_ff;
	logic [31:0] presc_ff;
	sbc_pwr_e pwr_ff;
	sbc_pwr_e nxt_pwr;

	wire logic cmd_wr = req.wr && (req.addr == ADDR_CMD_STAT);
	wire logic is_tmr = (req.wdata == CMD_STBY_TMR) ||
		(req.wdata == CMD_STBY_TMR_ALT);
	wire logic is_now = (req.wdata == CMD_STBY_NOW) ||
		(req.wdata == CMD_STBY_NOW_ALT);
	wire logic selected = drv_head_ff[DRV_SEL_BIT] == DRIVE_ID;
	wire logic stby_cmd = cmd_wr && (is_tmr || is_now) && selected;
	wire logic tmr_cmd = cmd_wr && is_tmr && selected;
	wire logic bad_sel = cmd_wr && (is_tmr || is_now) && !selected;
	wire logic media_cmd = cmd_wr && !(is_tmr || is_now) && selected;
	// Any read or write is host access and restarts the countdown.
	wire logic host_access = req.wr || req.rd;
	wire logic tmr_enabled = tmo_val_ff != 8'h00;
	// The prescaler turns clock cycles into one-second ticks; it restarts
	// with every access, so a restart always grants whole seconds.
	wire logic tick = presc_ff == 32'(TICK_CYCLES - 1);
	wire logic auto_expire = (pwr_ff == PWR_IDLE) && tmr_enabled &&
		!media_pend_ff && (secs_left_ff == 15'h0000) && !host_access;
	wire logic spun_up = (pwr_ff == PWR_SPIN_UP) && motor_at_speed;

	// Timeout value to seconds.
	// Values above the half-hour range are fixed special intervals.
	function automatic logic [14:0] tmo_secs(input logic [7:0] v);
		logic [14:0] w;
		w = {7'h00, v};
		if (v <= TMO_SHORT_MAX)
			tmo_secs = 15'(w * TMO_STEP_S);
		else if (v <= TMO_LONG_MAX)
			tmo_secs = 15'((w - 15'd240) * TMO_HALF_HOUR_S);
		else if (v == TMO_V252)
			tmo_secs = TMO_252_S;
		else if (v == TMO_V253)
			tmo_secs = TMO_253_S;
		else if (v == TMO_V254)
			tmo_secs = TMO_254_S;
		else
			tmo_secs = TMO_255_S;
	endfunction

	wire logic [14:0] full_secs = tmo_secs(tmo_val_ff);

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------

	// Standby commands and timeouts spin down; media commands spin up.
	always_comb begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			PWR_STBY: begin
				if (media_cmd)
					nxt_pwr = PWR_SPIN_UP;
			end
			PWR_SPIN_UP: begin
				if (stby_cmd)
					nxt_pwr = PWR_SPIN_DN;
				else if (motor_at_speed)
					nxt_pwr = PWR_IDLE;
			end
			PWR_IDLE: begin
				if (stby_cmd || auto_expire)
					nxt_pwr = PWR_SPIN_DN;
			end
			PWR_SPIN_DN: begin
				if (media_cmd)
					nxt_pwr = PWR_SPIN_UP;
				else if (motor_stopped)
					nxt_pwr = PWR_STBY;
			end
		endcase
	end

	// State, spindle command and standby flag.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			pwr_ff <= PWR_STBY;
			motor_on_ff <= 1'b0;
			standby_ff <= 1'b1;
		end else begin
			pwr_ff <= nxt_pwr;
			motor_on_ff <= (nxt_pwr == PWR_SPIN_UP) ||
				(nxt_pwr == PWR_IDLE);
			standby_ff <= (nxt_pwr == PWR_STBY) ||
				(nxt_pwr == PWR_SPIN_DN);
		end
	end

	// A media command waits until the spindle is at speed.
	// A standby command drops a pending media command, so no go pulse
	// can escape while the spindle is being stopped.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			media_pend_ff <= 1'b0;
			media_go_ff <= 1'b0;
		end else begin
			media_go_ff <= (media_cmd && pwr_ff == PWR_IDLE) ||
				(spun_up && media_pend_ff && !stby_cmd);
			if (stby_cmd || spun_up)
				media_pend_ff <= 1'b0;
			else if (media_cmd && pwr_ff != PWR_IDLE)
				media_pend_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Power-down timer
	// ----------------------------------------------------------------

	// Counts whole seconds only while idle; any access reloads it.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			presc_ff <= 32'h00000000;
			secs_left_ff <= 15'h0000;
		end else if (host_access || pwr_ff != PWR_IDLE) begin
			presc_ff <= 32'h00000000;
			secs_left_ff <= full_secs;
		end else if (tick) begin
			presc_ff <= 32'h00000000;
			if (secs_left_ff != 15'h0000)
				secs_left_ff <= secs_left_ff - 15'd1;
		end else begin
			presc_ff <= presc_ff + 32'd1;
		end
	end

	// ----------------------------------------------------------------
	// Task-file registers
	// ----------------------------------------------------------------

	// Host-written registers and the stored timeout.
	// The timed standby copies the count as it stood before the command.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sect_cnt_ff <= RST_SECT_CNT;
			drv_head_ff <= RST_DRV_HEAD;
			tmo_val_ff <= RST_TMO_VAL;
			irq_mask_ff <= RST_IRQ_MASK;
		end else begin
			if (req.wr && req.addr == ADDR_SECT_CNT)
				sect_cnt_ff <= req.wdata;
			if (req.wr && req.addr == ADDR_DRV_HEAD)
				drv_head_ff <= req.wdata;
			if (req.wr && req.addr == ADDR_IRQ_MASK)
				irq_mask_ff <= req.wdata[2:0];
			if (tmr_cmd)
				tmo_val_ff <= sect_cnt_ff;
		end
	end

	// Error result: only abort can be reported.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			err_ff <= 8'h00;
			err_flag_ff <= 1'b0;
		end else if (stby_cmd || bad_sel) begin
			err_ff <= {5'h00, bad_sel, 2'h0};
			err_flag_ff <= bad_sel;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// Events: bit 0 command done, bit 1 auto standby, bit 2 spun up.
	wire logic [2:0] irq_set = {spun_up, auto_expire, stby_cmd || bad_sel};
	wire logic irq_rd = req.rd && req.addr == ADDR_IRQ_STAT;

	// Sticky events; a read clears, a new event in that cycle wins.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			irq_stat_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= (irq_rd ? 3'h0 : irq_stat_ff) | irq_set;
			irq_ff <= |(((irq_rd ? 3'h0 : irq_stat_ff) | irq_set) &
				irq_mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// The seek-complete bit drops only while the spindle is ramping up.
	wire logic dsc = pwr_ff != PWR_SPIN_UP;
	wire logic [7:0] stat_val = {1'b0, 1'b1, 1'b0, dsc, 1'b0, 1'b0, 1'b0,
		err_flag_ff};
	wire logic [7:0] rd_mux =
		(req.addr == ADDR_CMD_STAT) ? stat_val :
		(req.addr == ADDR_ERR) ? err_ff :
		(req.addr == ADDR_SECT_CNT) ? sect_cnt_ff :
		(req.addr == ADDR_DRV_HEAD) ? drv_head_ff :
		(req.addr == ADDR_IRQ_STAT) ? {5'h00, irq_stat_ff} :
		(req.addr == ADDR_IRQ_MASK) ? {5'h00, irq_mask_ff} :
		(req.addr == ADDR_PWR_STAT) ? {6'h00, pwr_ff} :
		(req.addr == ADDR_TMO_VAL) ? tmo_val_ff : 8'h00;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge core_clk or negedge rst_n_ff) begin
		if (!rst_n_ff)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= req.rd ? rd_mux : 8'h00;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Decode, timeout storage, timer, power state, media and status checks; all idle during reset.
	chk_tmr_load_value: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) tmr_cmd |=> tmo_val_ff == $past(sect_cnt_ff))
		else $error("timeout not loaded from sector count");
	chk_now_keeps_tmo: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (stby_cmd && !tmr_cmd) |=> $stable(tmo_val_ff))
		else $error("immediate standby changed timeout");
	chk_stby_spins_dn: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (stby_cmd && pwr_ff == PWR_IDLE) |=>
		pwr_ff == PWR_SPIN_DN && !motor_on_ff)
		else $error("standby did not spin down");
	chk_stopped_stays: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (stby_cmd && pwr_ff == PWR_STBY) |=>
		pwr_ff == PWR_STBY && standby_ff)
		else $error("standby on stopped spindle left standby");
	chk_count_idle: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (pwr_ff != PWR_IDLE) |=>
		secs_left_ff == $past(full_secs))
		else $error("countdown ran outside idle");
	chk_access_reload: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (host_access && !tmr_cmd) |=>
		secs_left_ff == $past(full_secs))
		else $error("access did not restart countdown");
	chk_auto_standby: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) auto_expire |=> pwr_ff == PWR_SPIN_DN
		##0 irq_stat_ff[IRQ_AUTO_BIT])
		else $error("expiry did not enter standby");
	chk_no_auto_off: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (pwr_ff == PWR_IDLE && !tmr_enabled &&
		!stby_cmd) |=> pwr_ff == PWR_IDLE)
		else $error("zero timeout expired");
	chk_media_waits: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) media_go_ff |-> motor_on_ff && $past(
		pwr_ff == PWR_IDLE || motor_at_speed))
		else $error("media command before speed");
	chk_status_bits: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (req.rd && req.addr == ADDR_CMD_STAT) |=>
		rdata_ff[7] == 1'b0 && rdata_ff[6] && rdata_ff[5] == 1'b0 &&
		rdata_ff[2] == 1'b0 && rdata_ff[0] == err_ff[ERR_ABRT_BIT])
		else $error("completion status bits wrong");
	chk_long_table: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (tmo_val_ff == TMO_LONG_MAX) |->
		full_secs == 15'd19800)
		else $error("long timeout table wrong");
	chk_decode_alt: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (cmd_wr && selected && req.wdata == 8'h96)
		|-> tmr_cmd)
		else $error("alternate timed code not decoded");
	chk_decode_now: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (cmd_wr && selected && req.wdata == 8'h94)
		|-> stby_cmd && !tmr_cmd)
		else $error("alternate immediate code not decoded");

	// Interrupt status and completion flags.
	chk_irq_level: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) irq_ff == |(irq_stat_ff & $past(irq_mask_ff)))
		else $error("interrupt line does not follow status");
	chk_done_irq: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (stby_cmd || bad_sel) |=>
		irq_stat_ff[IRQ_DONE_BIT])
		else $error("command completion not flagged");
	chk_ready_irq: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) spun_up |=> irq_stat_ff[IRQ_READY_BIT] &&
		pwr_ff != PWR_SPIN_UP)
		else $error("spin-up completion not flagged");

	// Error, standby, read port and timeout table behaviour.
	chk_abort_keeps: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) bad_sel |=> err_ff[ERR_ABRT_BIT] &&
		err_ff[7:3] == 5'h00 && err_ff[1:0] == 2'h0 && $stable(tmo_val_ff))
		else $error("deselected standby did not abort");
	chk_standby_motor: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) pwr_ff == PWR_STBY |-> standby_ff &&
		!motor_on_ff)
		else $error("standby with spindle running");
	chk_rdata_idle: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) !req.rd |=> rdata_ff == 8'h00)
		else $error("read data outside its cycle");
	chk_short_table: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (tmo_val_ff == 8'hF0) |->
		full_secs == 15'h04B0)
		else $error("short timeout table wrong");

	// Media commands and spin-down completion against the spindle state.
	chk_media_pend: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (media_cmd && pwr_ff == PWR_STBY) |=>
		media_pend_ff && motor_on_ff && !media_go_ff)
		else $error("media command in standby not held");
	chk_idle_media_go: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (media_cmd && pwr_ff == PWR_IDLE) |=>
		media_go_ff && pwr_ff == PWR_IDLE)
		else $error("media command in idle not passed on");
	chk_spin_dn_stop: assert property (@(posedge core_clk)
		disable iff (!rst_n_ff) (pwr_ff == PWR_SPIN_DN && motor_stopped &&
		!media_cmd) |=> pwr_ff == PWR_STBY && standby_ff)
		else $error("stopped spindle did not reach standby");

endmodule

// ### tb_standby_power_command_handler.sv
// Self-checking bench for the standby command handler.
`timescale 1ns/1ns
module tb_standby_power_command_handler;
	import sbc_pkg::*;
	localparam int TICK = 4;
	localparam logic [7:0] CODES [4] = '{CMD_STBY_TMR, CMD_STBY_TMR_ALT,
		CMD_STBY_NOW, CMD_STBY_NOW_ALT};
	localparam logic [7:0] TVAL [6] = '{8'hF0, 8'hF1, 8'hF2, 8'hFC, 8'hFE,
		8'hFF};
	localparam int TSEC [6] = '{1200, 1800, 3600, 1260, 1270, 1275};
	logic core_clk;
	logic nrst;
	sbc_req_s req;
	logic motor_at_speed;
	logic motor_stopped;
	logic [7:0] rdata_ff;
	logic motor_on_ff;
	logic media_go_ff;
	logic standby_ff;
	logic irq_ff;
	logic [7:0] spin_cycles;
	logic [7:0] d;
	int failures;
	int checks;

	// ----------------------------------------------------------------
	// Design and spindle
	// ----------------------------------------------------------------
	sbc_top #(.TICK_CYCLES(TICK), .DRIVE_ID(1'b0)) i_dut (
		.core_clk(core_clk), .nrst(nrst), .req(req),
		.motor_at_speed(motor_at_speed), .motor_stopped(motor_stopped),
		.rdata_ff(rdata_ff), .motor_on_ff(motor_on_ff),
		.media_go_ff(media_go_ff), .standby_ff(standby_ff), .irq_ff(irq_ff)
	);
	sbc_motor_model i_motor (
		.core_clk(core_clk), .motor_on(motor_on_ff),
		.spin_cycles(spin_cycles), .motor_at_speed(motor_at_speed),
		.motor_stopped(motor_stopped)
	);

	// The clock toggles every half period of 100 ns.
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Prints the verdict and ends the run.
	task automatic test_done;
		if (failures == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Compares one byte and reports a mismatch.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// One-cycle register write.
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		req <= '{1'b1, 1'b0, a, v};
		@(posedge core_clk);
		req <= '0;
	endtask

	// One-cycle register read; data are taken in the following cycle.
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		req <= '0;
		@(negedge core_clk);
		v = rdata_ff;
	endtask

	// Reads a register and compares it.
	task automatic rdc(input logic [3:0] a, input logic [7:0] e,
		input string msg);
		logic [7:0] v;
		rd(a, v);
		chk(v, e, msg);
	endtask

	// Waits for go (0), standby (1) or spindle rest (2), bounded.
	task automatic wt(input int s, input int lim, output int n);
		n = 0;
		while ((s == 0 ? media_go_ff : s == 1 ? standby_ff : motor_stopped)
			!== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > lim) begin
				failures++;
				$display("[ERR] %0t wait %0d timed out", $time, s);
				test_done();
			end
		end
	endtask

	// Programs a timeout, spins up, and times the automatic standby; for a zero timeout checks that none comes and commands standby.
	task automatic run_tmo(input logic [7:0] v, input int ex, input int poke);
		int n;
		wr(ADDR_SECT_CNT, v);
		wr(ADDR_CMD_STAT, CMD_STBY_TMR);
		wt(2, 9000, n);
		wr(ADDR_CMD_STAT, 8'h20);
		if (spin_cycles > 8'd8) begin
			repeat (2) @(negedge core_clk);
			chk({7'h00, motor_on_ff}, 8'h01, "spin-up");
			rdc(ADDR_CMD_STAT, 8'h40, "busy spin status");
		end
		wt(0, 300, n);
		if (poke > 0) begin
			repeat (poke) @(negedge core_clk);
			rd(ADDR_CMD_STAT, d);
		end
		if (ex == 0) begin
			wr(ADDR_CMD_STAT, 8'h20);
			@(negedge core_clk);
			chk({7'h00, media_go_ff}, 8'h01, "idle media go");
			repeat (300) @(negedge core_clk);
			chk({7'h00, standby_ff}, 8'h00, "zero timeout");
			wr(ADDR_CMD_STAT, CMD_STBY_NOW);
		end else begin
			wt(1, ex + 50, n);
			chk({7'h00, n >= ex - TICK && n <= ex + TICK + 6}, 8'h01,
				"timeout length");
			chk({7'h00, motor_on_ff}, 8'h00, "spindle off");
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		failures = 0;
		checks = 0;
		nrst = 1'b0;
		req = '0;
		spin_cycles = 8'd3;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (5) @(posedge core_clk);
		rdc(ADDR_SECT_CNT, RST_SECT_CNT, "count reset");
		rdc(ADDR_DRV_HEAD, RST_DRV_HEAD, "head reset");
		rdc(ADDR_TMO_VAL, RST_TMO_VAL, "timeout reset");
		rdc(ADDR_IRQ_MASK, {5'h00, RST_IRQ_MASK}, "mask reset");
		rdc(ADDR_PWR_STAT, 8'h00, "power reset");
		rdc(4'hF, 8'h00, "unmapped");
		wr(ADDR_TMO_VAL, 8'h5A);
		rdc(ADDR_TMO_VAL, 8'h00, "read-only timeout");
		wr(ADDR_IRQ_MASK, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_SECT_CNT, 8'h10 + 8'(i));
			wr(ADDR_CMD_STAT, CODES[i]);
			repeat (2) @(negedge core_clk);
			chk({6'h00, motor_on_ff, irq_ff}, 8'h01, "cmd done");
			rdc(ADDR_IRQ_STAT, 8'h01, "done status");
			chk({7'h00, irq_ff}, 8'h00, "irq cleared");
			rdc(ADDR_PWR_STAT, 8'h00, "no spin-down");
			rdc(ADDR_CMD_STAT, 8'h50, "cmd status");
			rdc(ADDR_TMO_VAL, i < 2 ? 8'h10 + 8'(i) : 8'h11, "kept");
		end
		wr(ADDR_SECT_CNT, 8'hFB);
		wr(ADDR_CMD_STAT, CMD_STBY_TMR);
		rdc(ADDR_TMO_VAL, 8'hFB, "long value");
		wr(ADDR_DRV_HEAD, 8'hB0);
		wr(ADDR_CMD_STAT, CMD_STBY_NOW);
		rdc(ADDR_CMD_STAT, 8'h51, "abort status");
		rdc(ADDR_ERR, 8'h04, "abort cause");
		wr(ADDR_DRV_HEAD, 8'hA0);
		wr(ADDR_IRQ_MASK, 8'h02);
		rd(ADDR_IRQ_STAT, d);
		spin_cycles = 8'd40;
		run_tmo(8'h01, 5 * TICK, 0);
		chk({7'h00, irq_ff}, 8'h01, "auto irq");
		rd(ADDR_IRQ_STAT, d);
		chk(d & 8'h02, 8'h02, "auto status");
		chk({7'h00, irq_ff}, 8'h00, "auto irq clear");
		spin_cycles = 8'd2;
		run_tmo(8'h02, 10 * TICK, 30);
		run_tmo(8'h00, 0, 0);
		for (int i = 0; i < 6; i++) begin
			run_tmo(TVAL[i], TSEC[i] * TICK, 0);
		end
		test_done();
	end
endmodule
